/* File: smec_pkg.sv */
package smec_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned SMEC_CLK_MHZ      = 100;  // core clock, MHz
	localparam int unsigned SMEC_RATE_WIN_US  = 1000; // pulse rate window
	// cycles per rate window, derived from the window and the clock
	localparam int unsigned SMEC_RATE_WIN_CYC = SMEC_RATE_WIN_US * SMEC_CLK_MHZ;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] SMEC_OFS_CTRL = 8'h00; // mode, enable, direction
	localparam logic [7:0] SMEC_OFS_STAT = 8'h04; // live state, read only
	localparam logic [7:0] SMEC_OFS_PRE1 = 8'h08; // preset speed 1
	localparam logic [7:0] SMEC_OFS_PRE2 = 8'h0C; // preset speed 2
	localparam logic [7:0] SMEC_OFS_PRE3 = 8'h10; // preset speed 3
	localparam logic [7:0] SMEC_OFS_CMD  = 8'h14; // restart command
	localparam logic [7:0] SMEC_OFS_POS  = 8'h18; // position count

	// ****************************************************************
	// control word layout and reset values
	// ****************************************************************
	localparam int unsigned SMEC_MODE_LSB  = 0;  // control_mode_param digit
	localparam int unsigned SMEC_ENSRC_BIT = 4;  // function_select_param digit
	localparam int unsigned SMEC_REV_BIT   = 5;  // reverse rotation
	localparam int unsigned SMEC_SON_LSB   = 8;  // servo-on terminal index
	localparam int unsigned SMEC_CMD_RESTART_BIT = 0;
	localparam logic [31:0] SMEC_CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] SMEC_PRE_RST   = 16'h0000;

	// ****************************************************************
	// enumerations
	// ****************************************************************
	typedef enum logic [1:0] {
		SMEC_ST_OFF   = 2'b00,
		SMEC_ST_LOAD  = 2'b01,
		SMEC_ST_READY = 2'b11,
		SMEC_ST_RUN   = 2'b10
	} smec_state_t;

	typedef enum logic [1:0] {
		SMEC_M_SPEED  = 2'b00,
		SMEC_M_POS    = 2'b01,
		SMEC_M_TORQUE = 2'b10,
		SMEC_M_PRESET = 2'b11
	} smec_method_t;

endpackage : smec_pkg

/* File: smec_dir.sv */
`timescale 1ns/1ps
// direction conditioning: reverses references, never the feedback copies
module smec_dir
	import smec_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                rev,
	input  wire logic signed [W-1:0] spd_ref,
	input  wire logic signed [W-1:0] trq_ref,
	input  wire logic                step,
	input  wire logic                step_dir,
	input  wire logic                enc_a_fb,
	input  wire logic                enc_b_fb,
	input  wire logic [W-1:0]        mon_src,
	output logic signed [W-1:0]      spd_c,
	output logic signed [W-1:0]      trq_c,
	output logic                     step_c,
	output logic                     dir_c,
	output logic                     enc_a_div,
	output logic                     enc_b_div,
	output logic [W-1:0]             analog_mon
);

	// negate with saturation; the most negative code has no mirror
	function automatic logic signed [W-1:0] neg_sat(
		input logic signed [W-1:0] v
	);
		logic signed [W-1:0] lo;
		lo = {1'b1, {(W-1){1'b0}}};
		if (v == lo) begin
			neg_sat = ~lo;
		end else begin
			neg_sat = -v;
		end
	endfunction : neg_sat

	// references flip with rev, so the host keeps its own polarity
	always_ff @(posedge clk) begin
		if (rst) begin
			spd_c  <= '0;
			trq_c  <= '0;
			step_c <= 1'b0;
			dir_c  <= 1'b0;
		end else begin
			spd_c  <= rev ? neg_sat(spd_ref) : spd_ref;
			trq_c  <= rev ? neg_sat(trq_ref) : trq_ref;
			step_c <= step;
			dir_c  <= step_dir ^ rev;
		end
	end

	// feedback copies ignore rev: their polarity never changes
	always_ff @(posedge clk) begin
		if (rst) begin
			enc_a_div  <= 1'b0;
			enc_b_div  <= 1'b0;
			analog_mon <= '0;
		end else begin
			enc_a_div  <= enc_a_fb;
			enc_b_div  <= enc_b_fb;
			analog_mon <= mon_src;
		end
	end

endmodule : smec_dir

/* File: smec_top.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module smec_top
	import smec_pkg::*;
#(
	parameter int W        = 16,                 // reference width
	parameter int NTERM    = 8,                  // discrete terminals
	parameter int RATE_WIN = SMEC_RATE_WIN_CYC   // rate window, cycles
)(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic [31:0]              prdata,
	input  wire logic [NTERM-1:0]    term_n,
	input  wire logic                proportional_select_in_n,
	input  wire logic                forward_clamp_in_n,
	input  wire logic                reverse_clamp_in_n,
	input  wire logic signed [W-1:0] speed_ref,
	input  wire logic signed [W-1:0] torque_ref,
	input  wire logic                ref_pulse,
	input  wire logic                ref_pulse_dir,
	input  wire logic                drive_fault,
	input  wire logic                enc_a_fb,
	input  wire logic                enc_b_fb,
	input  wire logic [W-1:0]        mon_src,
	output logic                     servo_ready,
	output logic                     excite,
	output logic [1:0]               loop_sel,
	output logic signed [W-1:0]      speed_cmd,
	output logic signed [W-1:0]      torque_cmd,
	output logic signed [31:0]       pos_cmd,
	output logic                     enc_a_div,
	output logic                     enc_b_div,
	output logic [W-1:0]             analog_mon
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (W < 2 || W > 32) begin : g_bad_w
		$error("smec_top: W must be 2..32");
	end
	if (NTERM < 1 || NTERM > 8) begin : g_bad_term
		$error("smec_top: NTERM must be 1..8");
	end
	if (RATE_WIN < 1) begin : g_bad_win
		$error("smec_top: RATE_WIN must be at least 1");
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [31:0]         ctrl_r;           // software control word
	logic [W-1:0]        pre_r [1:3];      // preset speeds
	logic [3:0]          mode_act_r;       // mode held since start
	logic                ensrc_act_r;      // enable source held
	smec_state_t         state_r;          // enable sequencer
	smec_state_t         state_nxt;
	logic                restart;          // software restart strobe
	logic                son;              // servo-on, active high
	logic [2:0]          son_idx;          // selected terminal
	smec_method_t        method;           // method in force now
	logic signed [W-1:0] spd_c;            // direction-conditioned
	logic signed [W-1:0] trq_c;
	logic                step_c;
	logic                dir_c;
	logic signed [W-1:0] rate_cnt_r;       // pulses in this window
	logic signed [W-1:0] rate_r;           // pulses in last window
	logic [31:0]         win_r;            // window divider
	logic                wr_en;            // apb write strobe
	logic                run;

	assign run = (state_r == SMEC_ST_RUN);

	// ****************************************************************
	// apb slave: zero wait states, unmapped offsets error
	// ****************************************************************
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == SMEC_OFS_CTRL) || (a == SMEC_OFS_STAT) ||
			(a == SMEC_OFS_PRE1) || (a == SMEC_OFS_PRE2) ||
			(a == SMEC_OFS_PRE3) || (a == SMEC_OFS_CMD) ||
			(a == SMEC_OFS_POS);
	endfunction : mapped

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign wr_en   = psel && penable && pwrite && mapped(paddr);
	assign restart = wr_en && (paddr == SMEC_OFS_CMD) &&
		pwdata[SMEC_CMD_RESTART_BIT];

	// control word and presets; rev=0 reset means forward is ccw
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= SMEC_CTRL_RST;
			pre_r  <= '{default: SMEC_PRE_RST[W-1:0]};
		end else if (wr_en) begin
			case (paddr)
				SMEC_OFS_CTRL: ctrl_r   <= pwdata;
				SMEC_OFS_PRE1: pre_r[1] <= pwdata[W-1:0];
				SMEC_OFS_PRE2: pre_r[2] <= pwdata[W-1:0];
				SMEC_OFS_PRE3: pre_r[3] <= pwdata[W-1:0];
				default: ;
			endcase
		end
	end

	// read data captured in setup phase, valid through access
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				SMEC_OFS_CTRL: prdata <= ctrl_r;
				SMEC_OFS_STAT: prdata <= {22'h00_0000, loop_sel, son,
					ensrc_act_r, mode_act_r, state_r};
				SMEC_OFS_PRE1: prdata <= 32'(unsigned'(pre_r[1]));
				SMEC_OFS_PRE2: prdata <= 32'(unsigned'(pre_r[2]));
				SMEC_OFS_PRE3: prdata <= 32'(unsigned'(pre_r[3]));
				SMEC_OFS_POS:  prdata <= pos_cmd;
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// servo-on selection and start-up latching
	// ****************************************************************
	// terminal index is live; an index past the terminals reads off
	assign son_idx = ctrl_r[SMEC_SON_LSB +: 3];
	assign son = (32'(son_idx) < NTERM) ?
		!term_n[son_idx] : 1'b0;

	// mode and enable source only move in LOAD, i.e. after reset or a restart
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_act_r  <= SMEC_CTRL_RST[SMEC_MODE_LSB +: 4];
			ensrc_act_r <= SMEC_CTRL_RST[SMEC_ENSRC_BIT];
		end else if (state_r == SMEC_ST_LOAD) begin
			mode_act_r  <= ctrl_r[SMEC_MODE_LSB +: 4];
			ensrc_act_r <= ctrl_r[SMEC_ENSRC_BIT];
		end
	end

	// ****************************************************************
	// enable sequencer
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SMEC_ST_OFF:   state_nxt = SMEC_ST_LOAD;
			SMEC_ST_LOAD:  state_nxt = SMEC_ST_READY;
			SMEC_ST_READY: begin
				// ready shown first; auto mode runs the cycle after
				if (!drive_fault && (ensrc_act_r || son)) begin
					state_nxt = SMEC_ST_RUN;
				end
			end
			SMEC_ST_RUN: begin
				if (drive_fault || (!ensrc_act_r && !son)) begin
					state_nxt = SMEC_ST_READY;
				end
			end
			default:       state_nxt = SMEC_ST_OFF;
		endcase
		if (restart) begin
			state_nxt = SMEC_ST_OFF;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= SMEC_ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// excitation only in RUN; ready while no fault after loading
	always_ff @(posedge clk) begin
		if (rst) begin
			excite      <= 1'b0;
			servo_ready <= 1'b0;
		end else begin
			excite      <= (state_nxt == SMEC_ST_RUN);
			servo_ready <= !drive_fault && ((state_nxt == SMEC_ST_READY)
				|| (state_nxt == SMEC_ST_RUN));
		end
	end

	// ****************************************************************
	// method selection
	// ****************************************************************
	// switching modes: {method when input off, method when on}
	function automatic logic [3:0] mode_pair(input logic [3:0] m);
		case (m)
			4'h4:    mode_pair = {SMEC_M_PRESET, SMEC_M_SPEED};
			4'h5:    mode_pair = {SMEC_M_PRESET, SMEC_M_POS};
			4'h6:    mode_pair = {SMEC_M_PRESET, SMEC_M_TORQUE};
			4'h7:    mode_pair = {SMEC_M_POS, SMEC_M_SPEED};
			4'h8:    mode_pair = {SMEC_M_POS, SMEC_M_TORQUE};
			4'h9:    mode_pair = {SMEC_M_TORQUE, SMEC_M_SPEED};
			4'hA:    mode_pair = {SMEC_M_SPEED, SMEC_M_POS};
			4'hB:    mode_pair = {SMEC_M_SPEED, SMEC_M_TORQUE};
			4'hC:    mode_pair = {SMEC_M_TORQUE, SMEC_M_POS};
			4'hD:    mode_pair = {SMEC_M_SPEED, SMEC_M_PRESET};
			4'hE:    mode_pair = {SMEC_M_POS, SMEC_M_PRESET};
			default: mode_pair = {SMEC_M_SPEED, SMEC_M_SPEED};
		endcase
	endfunction : mode_pair

	always_comb begin
		logic [3:0] pr;
		pr = mode_pair(mode_act_r);
		if (mode_act_r < 4'h4) begin
			method = smec_method_t'(mode_act_r[1:0]);
		end else if (!proportional_select_in_n) begin
			method = smec_method_t'(pr[1:0]);
		end else begin
			method = smec_method_t'(pr[3:2]);
		end
	end

	// ****************************************************************
	// direction conditioning
	// ****************************************************************
	smec_dir #(.W(W)) u_dir (
		.clk        (clk),
		.rst        (rst),
		.rev        (ctrl_r[SMEC_REV_BIT]),
		.spd_ref    (speed_ref),
		.trq_ref    (torque_ref),
		.step       (ref_pulse),
		.step_dir   (ref_pulse_dir),
		.enc_a_fb   (enc_a_fb),
		.enc_b_fb   (enc_b_fb),
		.mon_src    (mon_src),
		.spd_c      (spd_c),
		.trq_c      (trq_c),
		.step_c     (step_c),
		.dir_c      (dir_c),
		.enc_a_div  (enc_a_div),
		.enc_b_div  (enc_b_div),
		.analog_mon (analog_mon)
	);

	// ****************************************************************
	// pulse train: position count and rate
	// ****************************************************************
	// pulses only count while energised and in position method
	always_ff @(posedge clk) begin
		if (rst) begin
			pos_cmd <= 32'sh0000_0000;
		end else if (run && method == SMEC_M_POS && step_c) begin
			pos_cmd <= dir_c ? pos_cmd - 32'sd1 : pos_cmd + 32'sd1;
		end
	end

	// window divider; rate wraps if a window overflows W bits
	always_ff @(posedge clk) begin
		if (rst) begin
			win_r      <= 32'h0000_0000;
			rate_cnt_r <= '0;
			rate_r     <= '0;
		end else if (win_r == 32'(RATE_WIN - 1)) begin
			win_r      <= 32'h0000_0000;
			rate_r     <= rate_cnt_r;
			rate_cnt_r <= '0;
		end else begin
			win_r <= win_r + 32'h0000_0001;
			if (step_c) begin
				rate_cnt_r <= dir_c ? rate_cnt_r - W'(1) :
					rate_cnt_r + W'(1);
			end
		end
	end

	// ****************************************************************
	// command outputs, zero whenever not energised
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			speed_cmd  <= '0;
			torque_cmd <= '0;
			loop_sel   <= SMEC_M_SPEED;
		end else begin
			loop_sel   <= method;
			speed_cmd  <= '0;
			torque_cmd <= '0;
			if (run) begin
				case (method)
					SMEC_M_SPEED:  speed_cmd <= spd_c;
					SMEC_M_POS:    speed_cmd <= rate_r;
					SMEC_M_TORQUE: torque_cmd <= trq_c;
					SMEC_M_PRESET: begin
						// clamp pair picks preset, none gives zero
						case ({!forward_clamp_in_n, !reverse_clamp_in_n})
							2'b10:   speed_cmd <= pre_r[1];
							2'b01:   speed_cmd <= pre_r[2];
							2'b11:   speed_cmd <= pre_r[3];
							default: speed_cmd <= '0;
						endcase
					end
					default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ready_auto;
		state_r == SMEC_ST_READY && ensrc_act_r && !drive_fault && !restart;
	endsequence
	sequence s_ready_son;
		state_r == SMEC_ST_READY && !ensrc_act_r && son && !drive_fault
			&& !restart;
	endsequence

	AST_SPEED_LOOP: assert property (run && method == SMEC_M_SPEED |=>
		speed_cmd == $past(spd_c) && torque_cmd == 0)
		else $error("speed command does not follow reference");
	AST_POS_UP: assert property (run && method == SMEC_M_POS && step_c
		&& !dir_c |=> pos_cmd == $past(pos_cmd) + 32'sd1)
		else $error("position count missed a forward pulse");
	AST_TORQUE: assert property (run && mode_act_r == 4'h2 |=>
		loop_sel == SMEC_M_TORQUE && torque_cmd == $past(trq_c))
		else $error("torque mode not followed");
	AST_PRESET_ZERO: assert property (run && method == SMEC_M_PRESET
		&& forward_clamp_in_n && reverse_clamp_in_n |=> speed_cmd == 0)
		else $error("preset zero speed not given");
	AST_SWITCH: assert property (mode_act_r >= 4'h4
		|=> loop_sel == $past(proportional_select_in_n ?
		mode_pair(mode_act_r) >> 2 : mode_pair(mode_act_r) & 4'h3))
		else $error("switching mode picked wrong method");
	AST_SON_RUN: assert property (s_ready_son |=> excite ##0 run)
		else $error("servo-on did not energise");
	AST_OFF_ZERO: assert property (!run |=> speed_cmd == 0
		&& torque_cmd == 0)
		else $error("command while not energised");
	AST_AUTO: assert property (s_ready_auto |=> excite ##0 servo_ready)
		else $error("auto enable did not follow ready");
	AST_HOLD: assert property (state_r != SMEC_ST_LOAD |=>
		$stable(mode_act_r) && $stable(ensrc_act_r))
		else $error("held setting changed without restart");
	AST_ENC: assert property (##1 enc_a_div == $past(enc_a_fb)
		&& analog_mon == $past(mon_src))
		else $error("feedback copy polarity changed");

endmodule : smec_top

/* File: smec_host.sv */
`timescale 1ns/1ps
// host controller model: servo-on terminal, references, pulse train
module smec_host #(
	parameter int W     = 16,
	parameter int NTERM = 8
)(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [2:0]          son_idx,   // terminal wired to servo-on
	input  wire logic                run_req,   // bench asks for motion
	input  wire logic signed [W-1:0] ref_val,   // reference to apply
	input  wire logic                pulse_go,  // bench asks for pulses
	input  wire logic                excite,    // drive energised
	output logic [NTERM-1:0]         term_n,
	output logic signed [W-1:0]      speed_ref,
	output logic signed [W-1:0]      torque_ref,
	output logic                     ref_pulse,
	output logic                     ref_pulse_dir
);
	logic son_r; // servo-on as held by the host

	// servo-on outlives the reference, so the motor never stops on it
	always_ff @(posedge clk) begin
		if (rst)
			son_r <= 1'b0;
		else
			son_r <= run_req | (speed_ref != '0);
	end

	// only the wired terminal goes low, all others rest high
	always_comb term_n = ~(NTERM'(son_r) << son_idx);

	// reference only after the drive is energised, removed first
	always_ff @(posedge clk) begin
		if (rst) begin
			speed_ref  <= '0;
			torque_ref <= '0;
			ref_pulse  <= 1'b0;
		end else begin
			speed_ref  <= (run_req & excite) ? ref_val : '0;
			torque_ref <= (run_req & excite) ? ref_val : '0;
			// every other cycle, so each pulse is a single cycle wide
			ref_pulse  <= pulse_go & excite & ~ref_pulse;
		end
	end

	// count up only; direction is the drive's business
	always_comb ref_pulse_dir = 1'b0;
endmodule : smec_host

/* File: tb_smec_top.sv */
`timescale 1ns/1ps
module tb_smec_top
	import smec_pkg::*;
;
	logic               clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd, p0;
	logic               er, prop_n, fcl_n, rcl_n, drive_fault;
	logic               enc_a_fb, enc_b_fb, enc_a_div, enc_b_div;
	logic [15:0]        mon_src, analog_mon;
	logic [7:0]         term_n;
	logic signed [15:0] speed_ref, torque_ref, speed_cmd, torque_cmd;
	logic signed [15:0] ref_val;    // host reference
	logic               ref_pulse, ref_pulse_dir, servo_ready, excite;
	logic [1:0]         loop_sel;
	logic signed [31:0] pos_cmd;
	logic [2:0]         son_idx;    // host wiring of servo-on
	logic               run_req, pulse_go;
	logic [3:0]         nib;        // expected method pair
	int                 failures, check_count;
	// off/on methods of modes 4 to F, four bits each
	localparam logic [47:0] SW_TAB = 48'hCDE4_6812_9370;

	always #5 clk = ~clk;

	smec_top #(.RATE_WIN(16)) i_smec_top (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .term_n(term_n),
		.proportional_select_in_n(prop_n), .forward_clamp_in_n(fcl_n),
		.reverse_clamp_in_n(rcl_n), .speed_ref(speed_ref),
		.torque_ref(torque_ref), .ref_pulse(ref_pulse),
		.ref_pulse_dir(ref_pulse_dir), .drive_fault(drive_fault),
		.enc_a_fb(enc_a_fb), .enc_b_fb(enc_b_fb), .mon_src(mon_src),
		.servo_ready(servo_ready), .excite(excite), .loop_sel(loop_sel),
		.speed_cmd(speed_cmd), .torque_cmd(torque_cmd), .pos_cmd(pos_cmd),
		.enc_a_div(enc_a_div), .enc_b_div(enc_b_div),
		.analog_mon(analog_mon));

	smec_host i_smec_host (.clk(clk), .rst(rst), .son_idx(son_idx),
		.run_req(run_req), .ref_val(ref_val), .pulse_go(pulse_go),
		.excite(excite), .term_n(term_n), .speed_ref(speed_ref),
		.torque_ref(torque_ref), .ref_pulse(ref_pulse),
		.ref_pulse_dir(ref_pulse_dir));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, waits for pready, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// bounded wait for the excitation level
	task automatic wait_ex(input logic v);
		int n;
		n = 0;
		while (excite !== v && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(excite, v);
	endtask : wait_ex

	// new control word, then restart as a supply cycle would
	task automatic start(input logic [31:0] c);
		int n;
		apb(1'b1, SMEC_OFS_CTRL, c);
		apb(1'b1, SMEC_OFS_CMD, 32'h0000_0001);
		n = 0;
		repeat (2) @(posedge clk);
		while (servo_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) failures++;
	endtask : start

	task automatic print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// watchdog: the whole sequence needs well under this
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{clk, psel, penable, pwrite, paddr, pwdata} = '0;
		{drive_fault, enc_a_fb, enc_b_fb, mon_src, run_req, pulse_go} = '0;
		{prop_n, fcl_n, rcl_n} = 3'b111;
		{failures, check_count} = '0;
		rst = 1'b1;
		son_idx = 3'd2;
		ref_val = 16'h0064;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, SMEC_OFS_CTRL, 32'h0000_0000);
		chk(rd, SMEC_CTRL_RST);
		apb(1'b0, 8'h1C, 32'h0000_0000);
		chk(er, 1'b1);
		chk(rd, 32'h0000_0000);
		// mode 0, servo-on on terminal 2, default direction
		start(32'h0000_0200);
		run_req <= 1'b1;
		wait_ex(1'b1);
		repeat (4) @(posedge clk);
		chk(loop_sel, SMEC_M_SPEED);
		chk(speed_cmd, ref_val);
		run_req <= 1'b0;
		wait_ex(1'b0);
		chk(speed_cmd, 32'h0000_0000);
		// host wired to terminal 5 while terminal 2 is selected
		son_idx <= 3'd5;
		run_req <= 1'b1;
		repeat (20) @(posedge clk);
		chk(excite, 1'b0);
		// mode change without restart is not taken
		apb(1'b1, SMEC_OFS_CTRL, 32'h0000_0502);
		apb(1'b0, SMEC_OFS_STAT, 32'h0000_0000);
		chk(rd[5:2], 4'h0);
		start(32'h0000_0502);
		wait_ex(1'b1);
		repeat (4) @(posedge clk);
		chk(loop_sel, SMEC_M_TORQUE);
		chk(torque_cmd, ref_val);
		// pulse train in position mode
		start(32'h0000_0501);
		wait_ex(1'b1);
		repeat (4) @(posedge clk);
		chk(loop_sel, SMEC_M_POS);
		p0 = pos_cmd;
		pulse_go <= 1'b1;
		repeat (10) @(posedge clk);
		pulse_go <= 1'b0;
		repeat (4) @(posedge clk);
		chk(pos_cmd - p0, 32'h0000_0005);
		// presets chosen by the two clamp inputs
		for (int k = 1; k < 4; k++)
			apb(1'b1, SMEC_OFS_PRE1 + 8'(4 * (k - 1)), 32'h0101 * k);
		start(32'h0000_0503);
		wait_ex(1'b1);
		for (int i = 0; i < 4; i++) begin
			fcl_n <= ~i[0];
			rcl_n <= ~i[1];
			repeat (4) @(posedge clk);
			chk(speed_cmd, 32'h0101 * i);
		end
		{fcl_n, rcl_n} <= 2'b11;
		// every switching mode, proportional input off then on
		for (int m = 4; m < 16; m++) begin
			start(32'h0000_0500 | m);
			wait_ex(1'b1);
			nib = SW_TAB[4 * (15 - m) +: 4];
			repeat (4) @(posedge clk);
			chk(loop_sel, nib[3:2]);
			prop_n <= 1'b0;
			repeat (4) @(posedge clk);
			chk(loop_sel, nib[1:0]);
			prop_n <= 1'b1;
		end
		// reversed rotation, feedback copies keep their polarity
		start(32'h0000_0520);
		wait_ex(1'b1);
		repeat (4) @(posedge clk);
		chk(speed_cmd, -ref_val);
		for (int j = 0; j < 2; j++) begin
			{enc_a_fb, enc_b_fb} <= j[0] ? 2'b01 : 2'b10;
			mon_src <= j[0] ? 16'hEDCB : 16'h1234;
			repeat (3) @(posedge clk);
			chk({enc_a_div, enc_b_div, analog_mon},
				{j[0] ? 2'b01 : 2'b10, j[0] ? 16'hEDCB : 16'h1234});
		end
		// automatic enable only after a restart
		run_req <= 1'b0;
		wait_ex(1'b0);
		repeat (4) @(posedge clk);
		apb(1'b1, SMEC_OFS_CTRL, 32'h0000_0510);
		repeat (20) @(posedge clk);
		chk(excite, 1'b0);
		apb(1'b1, SMEC_OFS_CMD, 32'h0000_0001);
		repeat (2) @(posedge clk);
		wait_ex(1'b1);
		chk(servo_ready, 1'b1);
		// a fault drops ready and power; auto enable returns after it
		drive_fault <= 1'b1;
		wait_ex(1'b0);
		repeat (2) @(posedge clk);
		chk(servo_ready, 1'b0);
		drive_fault <= 1'b0;
		wait_ex(1'b1);
		print_verdict();
	end
endmodule : tb_smec_top
